// File: dma_evt_pkg.sv
// Package with register map, field positions and reset values
package dma_evt_pkg;

  // Register byte addresses
  localparam logic [3:0] ADDR_EVENT_CTRL = 4'h0;
  localparam logic [3:0] ADDR_INT_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_CHAN_CTRL  = 4'h8;
  localparam logic [3:0] ADDR_SIZES      = 4'hC;

  // Event control fields
  localparam int ABORT_SEL_LSB  = 16;
  localparam int START_SEL_LSB  = 8;
  localparam int FORCE_BIT      = 7;
  localparam int SWABORT_BIT    = 6;
  localparam int PATTERN_ABORT_EN_BIT      = 5;
  localparam int STARTEN_BIT    = 4;
  localparam int ABORTEN_BIT    = 3;
  localparam logic [7:0] SEL_RESET = 8'hFF;

  // Interrupt control fields
  localparam int IE_LSB         = 16;
  localparam int FL_SRC_DONE    = 7;
  localparam int FL_SRC_HALF    = 6;
  localparam int FL_DST_DONE    = 5;
  localparam int FL_DST_HALF    = 4;
  localparam int FL_BLOCK       = 3;
  localparam int FL_CELL        = 2;
  localparam int FL_ABORT       = 1;
  localparam int FL_ADDR_ERR    = 0;

  // Channel control fields
  localparam int CHANNEL_ENABLE_BIT       = 7;
  localparam int EVOFF_BIT      = 6;
  localparam int AUTOEN_BIT     = 4;
  localparam int BUSY_BIT       = 15;

  // Sizes register fields
  localparam int DSIZE_LSB      = 16;

endpackage : dma_evt_pkg

// File: dma_channel_event_irq_ctrl.sv
// Channel event, abort and interrupt flag control for one DMA channel
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module dma_channel_event_irq_ctrl #(
  parameter int PTR_W = 16                   // Pointer and size width
) (
  input  wire logic              CLK_SYS_I,     // System clock 100 MHz
  input  wire logic              SYS_RST_I,     // Async reset, high
  input  wire logic [3:0]        ADDR_I,        // Register byte address
  input  wire logic [31:0]       WDATA_I,       // Write data
  input  wire logic              WR_I,          // Write strobe
  input  wire logic              RD_I,          // Read strobe
  output logic      [31:0]       RDATA_O,       // Read data, cycle after
  input  wire logic              IRQ_VALID_I,   // System irq event pulse
  input  wire logic [7:0]        IRQ_NUM_I,     // System irq number
  input  wire logic [PTR_W-1:0]  SRC_PTR_I,     // Source pointer
  input  wire logic [PTR_W-1:0]  DST_PTR_I,     // Destination pointer
  input  wire logic              PTR_STEP_I,    // Pointers just moved
  input  wire logic              CELL_DONE_I,   // Cell finished pulse
  input  wire logic              BLOCK_DONE_I,  // Block finished pulse
  input  wire logic              PAT_MATCH_I,   // Pattern match pulse
  input  wire logic              ADDR_ERR_I,    // Invalid address pulse
  input  wire logic              BUSY_I,        // Engine is active
  output logic                   START_O,       // Start one cell, pulse
  output logic                   ABORT_O,       // Abort transfer, pulse
  output logic                   CHAN_EN_O,     // Channel enable level
  output logic                   IRQ_O          // Channel interrupt
);


  // Event control register fields
  logic [7:0]       abort_sel;         // Abort irq number
  logic [7:0]       start_sel;         // Start irq number
  logic             pattern_abort_en;  // Match aborts channel
  logic             start_trigger_en;  // Start irq gate
  logic             abort_trigger_en;  // Abort irq gate

  // Interrupt control register fields
  logic [7:0]       irq_ie;            // Per flag enables
  logic [7:0]       irq_flag;          // Sticky status flags

  // Channel control and sizes
  logic             channel_enable;    // Channel is on
  logic             events_when_off;   // React while off
  logic             auto_reenable;     // Stay on after block
  logic [PTR_W-1:0] source_size;       // Programmed src size
  logic [PTR_W-1:0] dest_size;         // Programmed dst size
  logic             busy_seen;         // Engine busy, registered

  // Register bus decode
  logic             wr_evt;            // Write to event control
  logic             wr_int;            // Write to interrupt control
  logic             wr_chan;           // Write to channel control
  logic             wr_size;           // Write to sizes

  // Event qualification
  logic             ev_ok;             // Events may act now
  logic             start_num_hit;     // Irq number equals start
  logic             abort_num_hit;     // Irq number equals abort
  logic             irq_start;         // Gated start irq
  logic             irq_abort;         // Gated abort irq
  logic             sw_force;          // Software start strobe
  logic             sw_abort;          // Software abort strobe
  logic             pat_abort;         // Enabled pattern abort
  logic             do_abort;          // Any abort cause
  logic             do_start;          // Start that survives abort

  // Pointer compares
  logic             src_at_end;        // Source pointer at size
  logic             src_at_half;       // Source pointer at half
  logic             dst_at_end;        // Dest pointer at size
  logic             dst_at_half;       // Dest pointer at half

  // Flag update terms
  logic [7:0]       flag_set;          // Hardware set terms
  logic [7:0]       pending;           // Flags that are enabled

  // Read views of each register
  logic [31:0]      evt_view;          // Event control word
  logic [31:0]      int_view;          // Interrupt control word
  logic [31:0]      chan_view;         // Channel control word
  logic [31:0]      size_view;         // Sizes word
  logic [31:0]      next_rdata;        // Selected read word

  // Half point of a size; size zero compares raw
  function automatic logic [PTR_W-1:0] half_of(
    input logic [PTR_W-1:0] s
  );
    half_of = s >> 1;
  endfunction : half_of

  // Address match, shared by every write decode
  function automatic logic reg_hit(
    input logic [3:0] a,
    input logic [3:0] target
  );
    reg_hit = (a == target);
  endfunction : reg_hit

  // Write decode; a write to an unmapped address does nothing
  assign wr_evt  = WR_I && reg_hit(ADDR_I, dma_evt_pkg::ADDR_EVENT_CTRL);
  assign wr_int  = WR_I && reg_hit(ADDR_I, dma_evt_pkg::ADDR_INT_CTRL);
  assign wr_chan = WR_I && reg_hit(ADDR_I, dma_evt_pkg::ADDR_CHAN_CTRL);
  assign wr_size = WR_I && reg_hit(ADDR_I, dma_evt_pkg::ADDR_SIZES);

  // Pointer compares, only used on a step pulse
  assign src_at_end  = (SRC_PTR_I == source_size);
  assign src_at_half = (SRC_PTR_I == half_of(source_size));
  assign dst_at_end  = (DST_PTR_I == dest_size);
  assign dst_at_half = (DST_PTR_I == half_of(dest_size));

  // Events count while enabled, or always if allowed when off
  assign ev_ok = channel_enable || events_when_off;

  // Irq number compare against both selects
  assign start_num_hit = (IRQ_NUM_I == start_sel);
  assign abort_num_hit = (IRQ_NUM_I == abort_sel);

  // Gated irq triggers
  assign irq_start = IRQ_VALID_I && start_trigger_en
                     && start_num_hit && ev_ok;
  assign irq_abort = IRQ_VALID_I && abort_trigger_en
                     && abort_num_hit && ev_ok;

  // Software strobes act on the write, nothing is stored
  assign sw_force = wr_evt && WDATA_I[dma_evt_pkg::FORCE_BIT];
  assign sw_abort = wr_evt && WDATA_I[dma_evt_pkg::SWABORT_BIT];

  // Pattern match aborts only when enabled
  assign pat_abort = PAT_MATCH_I && pattern_abort_en;

  // Any abort cause; an abort beats a start in the same cycle
  assign do_abort = irq_abort || sw_abort || pat_abort;
  assign do_start = (irq_start || sw_force) && !do_abort;

  // Hardware set terms, one per flag position
  always_comb begin
    flag_set = 8'h00;
    flag_set[dma_evt_pkg::FL_SRC_DONE] = PTR_STEP_I && src_at_end;
    flag_set[dma_evt_pkg::FL_SRC_HALF] = PTR_STEP_I && src_at_half;
    flag_set[dma_evt_pkg::FL_DST_DONE] = PTR_STEP_I && dst_at_end;
    flag_set[dma_evt_pkg::FL_DST_HALF] = PTR_STEP_I && dst_at_half;
    flag_set[dma_evt_pkg::FL_BLOCK]    = BLOCK_DONE_I
                                         || PAT_MATCH_I;
    flag_set[dma_evt_pkg::FL_CELL]     = CELL_DONE_I;
    flag_set[dma_evt_pkg::FL_ABORT]    = irq_abort;
    flag_set[dma_evt_pkg::FL_ADDR_ERR] = ADDR_ERR_I;
  end

  // Irq number selects
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      abort_sel <= dma_evt_pkg::SEL_RESET;
      start_sel <= dma_evt_pkg::SEL_RESET;
    end else if (wr_evt) begin
      abort_sel <= WDATA_I[dma_evt_pkg::ABORT_SEL_LSB +: 8];
      start_sel <= WDATA_I[dma_evt_pkg::START_SEL_LSB +: 8];
    end
  end

  // Trigger enables of the event control register
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pattern_abort_en <= 1'b0;
      start_trigger_en <= 1'b0;
      abort_trigger_en <= 1'b0;
    end else if (wr_evt) begin
      pattern_abort_en <= WDATA_I[dma_evt_pkg::PATTERN_ABORT_EN_BIT];
      start_trigger_en <= WDATA_I[dma_evt_pkg::STARTEN_BIT];
      abort_trigger_en <= WDATA_I[dma_evt_pkg::ABORTEN_BIT];
    end
  end

  // Interrupt enables
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_ie <= 8'h00;
    end else if (wr_int) begin
      irq_ie <= WDATA_I[dma_evt_pkg::IE_LSB +: 8];
    end
  end

  // Sticky flags; a hardware set wins over a software clear
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      irq_flag <= 8'h00;
    end else if (wr_int) begin
      irq_flag <= WDATA_I[7:0] | flag_set;
    end else begin
      irq_flag <= irq_flag | flag_set;
    end
  end

  // Flags whose interrupt is enabled, bit for bit
  assign pending = irq_flag & irq_ie;

  // Channel mode bits: events when off, auto enable
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      events_when_off <= 1'b0;
      auto_reenable   <= 1'b0;
    end else if (wr_chan) begin
      events_when_off <= WDATA_I[dma_evt_pkg::EVOFF_BIT];
      auto_reenable   <= WDATA_I[dma_evt_pkg::AUTOEN_BIT];
    end
  end

  // Channel enable; hardware clears beat a same-cycle write
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      channel_enable <= 1'b0;
    end else if (pat_abort) begin
      channel_enable <= 1'b0;
    end else if (BLOCK_DONE_I && !auto_reenable) begin
      channel_enable <= 1'b0;
    end else if (wr_chan) begin
      channel_enable <= WDATA_I[dma_evt_pkg::CHANNEL_ENABLE_BIT];
    end
  end

  // Programmed source size
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      source_size <= '0;
    end else if (wr_size) begin
      source_size <= WDATA_I[PTR_W-1:0];
    end
  end

  // Programmed destination size
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dest_size <= '0;
    end else if (wr_size) begin
      dest_size <= WDATA_I[dma_evt_pkg::DSIZE_LSB +: PTR_W];
    end
  end

  // Abort command pulse to the engine
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ABORT_O <= 1'b0;
    end else begin
      ABORT_O <= do_abort;
    end
  end

  // Start command pulse, dropped when an abort shares the cycle
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      START_O <= 1'b0;
    end else begin
      START_O <= do_start;
    end
  end

  // Channel enable level seen by the engine
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CHAN_EN_O <= 1'b0;
    end else begin
      CHAN_EN_O <= channel_enable;
    end
  end

  // Channel interrupt request
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |pending;
    end
  end

  // Engine busy level, registered for read back
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      busy_seen <= 1'b0;
    end else begin
      busy_seen <= BUSY_I;
    end
  end

  // Event control as software sees it; strobe bits read zero
  always_comb begin
    evt_view = 32'h0000_0000;
    evt_view[dma_evt_pkg::ABORT_SEL_LSB +: 8] = abort_sel;
    evt_view[dma_evt_pkg::START_SEL_LSB +: 8] = start_sel;
    evt_view[dma_evt_pkg::PATTERN_ABORT_EN_BIT]   = pattern_abort_en;
    evt_view[dma_evt_pkg::STARTEN_BIT] = start_trigger_en;
    evt_view[dma_evt_pkg::ABORTEN_BIT] = abort_trigger_en;
  end

  // Interrupt control word; middle byte reads zero
  always_comb begin
    int_view = 32'h0000_0000;
    int_view[dma_evt_pkg::IE_LSB +: 8] = irq_ie;
    int_view[7:0] = irq_flag;
  end

  // Channel control word
  always_comb begin
    chan_view = 32'h0000_0000;
    chan_view[dma_evt_pkg::BUSY_BIT]   = busy_seen;
    chan_view[dma_evt_pkg::CHANNEL_ENABLE_BIT]   = channel_enable;
    chan_view[dma_evt_pkg::EVOFF_BIT]  = events_when_off;
    chan_view[dma_evt_pkg::AUTOEN_BIT] = auto_reenable;
  end

  // Sizes word, source low and destination high
  always_comb begin
    size_view = 32'h0000_0000;
    size_view[PTR_W-1:0] = source_size;
    size_view[dma_evt_pkg::DSIZE_LSB +: PTR_W] = dest_size;
  end

  // Read select; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (ADDR_I)
      dma_evt_pkg::ADDR_EVENT_CTRL: next_rdata = evt_view;
      dma_evt_pkg::ADDR_INT_CTRL:   next_rdata = int_view;
      dma_evt_pkg::ADDR_CHAN_CTRL:  next_rdata = chan_view;
      dma_evt_pkg::ADDR_SIZES:      next_rdata = size_view;
      default:                      next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RD_I) begin
      RDATA_O <= next_rdata;
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

endmodule : dma_channel_event_irq_ctrl

// File: dma_evt_src_model.sv
// Model of irq sources and transfer engine beside the channel
`timescale 1ns/100ps
module dma_evt_src_model (
  input  wire logic  clk_i,      // Clock
  output logic       valid_o,    // Irq event
  output logic [7:0] num_o,      // Irq number
  output logic [15:0] sp_o,      // Src ptr
  output logic [15:0] dp_o,      // Dst ptr
  output logic [4:0] ev_o        // Step,cell,block,match,err
);
  // Quiet lines at time zero
  initial begin
    valid_o = 1'b0;
    num_o = 8'h00;
    sp_o = 16'h0000;
    dp_o = 16'h0000;
    ev_o = 5'h00;
  end
  // One irq event; number shows its inverse once idle
  task automatic fire(input logic [7:0] n);
    @(posedge clk_i);
    valid_o <= 1'b1;
    num_o <= n;
    @(posedge clk_i);
    valid_o <= 1'b0;
    num_o <= ~n;
    #1;
  endtask : fire
  // One engine pulse with pointers; pointers scrambled after
  task automatic pulse(input logic [4:0] e, input logic [15:0] s, d);
    @(posedge clk_i);
    ev_o <= e;
    sp_o <= s;
    dp_o <= d;
    @(posedge clk_i);
    ev_o <= 5'h00;
    sp_o <= ~s;
    dp_o <= ~d;
    #1;
  endtask : pulse
endmodule : dma_evt_src_model

// File: dma_channel_event_irq_ctrl_chk.sv
// Port assertions for the channel event and irq control
`timescale 1ns/100ps
module dma_channel_event_irq_ctrl_chk #(
  parameter int PTR_W = 16  // Ptr width
) (
  input wire logic             CLK_SYS_I,    // Clk
  input wire logic             SYS_RST_I,    // Rst
  input wire logic [3:0]       ADDR_I,       // Addr
  input wire logic [31:0]      WDATA_I,      // Wdata
  input wire logic             WR_I,         // Write
  input wire logic             RD_I,         // Read
  input wire logic [31:0]      RDATA_O,      // Rdata
  input wire logic             IRQ_VALID_I,  // Irq
  input wire logic [7:0]       IRQ_NUM_I,    // Irq num
  input wire logic [PTR_W-1:0] SRC_PTR_I,    // Src ptr
  input wire logic [PTR_W-1:0] DST_PTR_I,    // Dst ptr
  input wire logic             PTR_STEP_I,   // Step
  input wire logic             CELL_DONE_I,  // Cell
  input wire logic             BLOCK_DONE_I, // Block
  input wire logic             PAT_MATCH_I,  // Match
  input wire logic             ADDR_ERR_I,   // Error
  input wire logic             BUSY_I,       // Busy
  input wire logic             START_O,      // Start
  input wire logic             ABORT_O,      // Abort
  input wire logic             CHAN_EN_O,    // Enable
  input wire logic             IRQ_O         // Irq out
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);
  // Decoded register writes
  wire ev_wr = WR_I && (ADDR_I == 4'h0);
  wire ie_wr = WR_I && (ADDR_I == 4'h4);
  wire ch_wr = WR_I && (ADDR_I == 4'h8);
  property p_force; ev_wr && WDATA_I[7] && !WDATA_I[6] && !IRQ_VALID_I
    && !PAT_MATCH_I |=> START_O; endproperty
  a_force: assert property (p_force) else $error("force lost");
  property p_swab; ev_wr && WDATA_I[6] |=> ABORT_O; endproperty
  a_swab: assert property (p_swab) else $error("abort lost");
  property p_evz; RD_I && ADDR_I == 4'h0 |=> RDATA_O[31:24] == 8'h00
    && RDATA_O[7:6] == 2'h0 && RDATA_O[2:0] == 3'h0; endproperty
  a_evz: assert property (p_evz) else $error("evt bits");
  property p_intz; RD_I && ADDR_I == 4'h4 |=> RDATA_O[31:24] == 8'h00
    && RDATA_O[15:8] == 8'h00; endproperty
  a_intz: assert property (p_intz) else $error("int bits");
  property p_stc; START_O |-> $past(IRQ_VALID_I || (ev_wr && WDATA_I[7]));
  endproperty
  a_stc: assert property (p_stc) else $error("stray start");
  property p_abc; ABORT_O |-> $past(IRQ_VALID_I || PAT_MATCH_I
    || (ev_wr && WDATA_I[6])); endproperty
  a_abc: assert property (p_abc) else $error("stray abort");
  property p_irqoff; ie_wr && WDATA_I[23:16] == 8'h00 |-> ##2 !IRQ_O;
  endproperty
  a_irqoff: assert property (p_irqoff) else $error("irq masked");
  property p_enon; ch_wr && WDATA_I[7] && !BLOCK_DONE_I && !PAT_MATCH_I
    |-> ##2 CHAN_EN_O; endproperty
  a_enon: assert property (p_enon) else $error("enable lost");
  c_start: cover property (START_O);
  c_abort: cover property (ABORT_O);
  c_irq: cover property (IRQ_O);
endmodule : dma_channel_event_irq_ctrl_chk
bind dma_channel_event_irq_ctrl dma_channel_event_irq_ctrl_chk
  #(.PTR_W(PTR_W)) u_chk (.CLK_SYS_I, .SYS_RST_I, .ADDR_I, .WDATA_I,
  .WR_I, .RD_I, .RDATA_O, .IRQ_VALID_I, .IRQ_NUM_I, .SRC_PTR_I,
  .DST_PTR_I, .PTR_STEP_I, .CELL_DONE_I, .BLOCK_DONE_I, .PAT_MATCH_I,
  .ADDR_ERR_I, .BUSY_I, .START_O, .ABORT_O, .CHAN_EN_O, .IRQ_O);

// File: dma_channel_event_irq_ctrl_tb_top.sv
// Bench for the channel event and irq control
`timescale 1ns/100ps
module dma_channel_event_irq_ctrl_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        vld, st, ab, en, irq;
  logic [7:0]  num;
  logic [15:0] sp, dp;
  logic [4:0]  ev;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // Flag cases: event byte, src ptr, dst ptr, flag byte
  logic [47:0] tab [7] = '{48'h1000_1000_0080, 48'h1000_0800_0040,
    48'h1000_0000_2020, 48'h1000_0000_1010, 48'h0400_0000_0008,
    48'h0800_0000_0004, 48'h0100_0000_0001};
  // Clock and timeout
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      end_of_test();
    end
  end
  dma_evt_src_model u_dma_evt_src_model (.clk_i(clk), .valid_o(vld),
    .num_o(num), .sp_o(sp), .dp_o(dp), .ev_o(ev));
  dma_channel_event_irq_ctrl u_dma_channel_event_irq_ctrl (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_VALID_I(vld),
    .IRQ_NUM_I(num), .SRC_PTR_I(sp), .DST_PTR_I(dp), .PTR_STEP_I(ev[4]),
    .CELL_DONE_I(ev[3]), .BLOCK_DONE_I(ev[2]), .PAT_MATCH_I(ev[1]),
    .ADDR_ERR_I(ev[0]), .BUSY_I(1'b0), .START_O(st), .ABORT_O(ab),
    .CHAN_EN_O(en), .IRQ_O(irq));
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk
  task automatic fire_exp(input logic [7:0] n, input logic [1:0] e);
    u_dma_evt_src_model.fire(n);
    chk(32'({st, ab}), 32'(e));
  endtask : fire_exp
  task automatic t_regs();
    rd_chk(4'h0, 32'h00FF_FF00);
    rd_chk(4'h2, 32'h0000_0000);
    wr_reg(4'h0, 32'hFFAB_CDFF);
    chk(32'({st, ab}), 32'h0000_0001);
    rd_chk(4'h0, 32'h00AB_CD38);
    wr_reg(4'h4, 32'hFFFF_FFFF);
    rd_chk(4'h4, 32'h00FF_00FF);
    wr_reg(4'h0, 32'h0021_1298);
    chk(32'({st, ab}), 32'h0000_0002);
  endtask : t_regs
  task automatic t_irq();
    wr_reg(4'h4, 32'h0000_0000);
    wr_reg(4'h8, 32'h0000_0080);
    fire_exp(8'h12, 2'b10);
    fire_exp(8'h21, 2'b01);
    rd_chk(4'h4, 32'h0000_0002);
    fire_exp(8'h13, 2'b00);
    wr_reg(4'h0, 32'h0021_1200);
    fire_exp(8'h12, 2'b00);
    fire_exp(8'h21, 2'b00);
    wr_reg(4'h0, 32'h0021_1218);
    wr_reg(4'h8, 32'h0000_0000);
    fire_exp(8'h12, 2'b00);
    wr_reg(4'h8, 32'h0000_0040);
    fire_exp(8'h21, 2'b01);
  endtask : t_irq
  task automatic t_flags();
    wr_reg(4'h4, 32'h00FF_0000);
    wr_reg(4'hC, 32'h0020_0010);
    for (int i = 0; i < 7; i++) begin
      u_dma_evt_src_model.pulse(tab[i][44:40], tab[i][39:24], tab[i][23:8]);
      rd_chk(4'h4, {16'h00FF, 8'h00, tab[i][7:0]});
      chk(32'(irq), 32'h0000_0001);
      wr_reg(4'h4, 32'h00FF_0000);
    end
    wr_reg(4'h4, 32'h007F_0080);
    @(posedge clk);
    #1;
    chk(32'(irq), 32'h0000_0000);
  endtask : t_flags
  task automatic t_block();
    wr_reg(4'h8, 32'h0000_0080);
    u_dma_evt_src_model.pulse(5'h04, 16'h0000, 16'h0000);
    rd_chk(4'h8, 32'h0000_0000);
    wr_reg(4'h8, 32'h0000_0090);
    u_dma_evt_src_model.pulse(5'h04, 16'h0000, 16'h0000);
    rd_chk(4'h8, 32'h0000_0090);
    chk(32'(en), 32'h0000_0001);
    wr_reg(4'h0, 32'h0021_1200);
    u_dma_evt_src_model.pulse(5'h02, 16'h0000, 16'h0000);
    chk(32'(ab), 32'h0000_0000);
    wr_reg(4'h4, 32'h0000_0000);
    wr_reg(4'h0, 32'h0021_1220);
    u_dma_evt_src_model.pulse(5'h02, 16'h0000, 16'h0000);
    chk(32'(ab), 32'h0000_0001);
    rd_chk(4'h4, 32'h0000_0008);
    rd_chk(4'h8, 32'h0000_0010);
  endtask : t_block
  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Reset, scenarios, verdict
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_irq();
    t_flags();
    t_block();
    end_of_test();
  end
endmodule : dma_channel_event_irq_ctrl_tb_top
